// ---- rtl/eltsc_defines.vh ----
`ifndef ELTSC_DEFINES_VH
`define ELTSC_DEFINES_VH
// Register offsets
`define ELTSC_ADDR_LINE_IFACE   8'h16
`define ELTSC_ADDR_LINE_TEST    8'h1F
`define ELTSC_ADDR_SIG_OUT      8'h2F
`define ELTSC_ADDR_SIG_BASE     8'h30
`define ELTSC_SIG_COUNT         16
// Field positions
`define ELTSC_BIT_LINE_SYNC     5
`define ELTSC_BIT_TSYNC         0
`define ELTSC_BIT_LOOPBACK      2
`define ELTSC_BIT_RATIO         3
`define ELTSC_BIT_OTM_HI        7
`define ELTSC_BIT_OTM_LO        6
`define ELTSC_BIT_SIG_RD_SEL    5
`define ELTSC_BIT_STSEL         4
`define ELTSC_BIT_TS16_INS      3
`define ELTSC_BIT_SWRST         0
// Writable masks (unused bits read zero)
`define ELTSC_MASK_LINE_TEST    8'h0D
`define ELTSC_MASK_SIG_OUT      8'hF9
// Reset values
`define ELTSC_RST_BYTE          8'h00
// Output test codes
`define ELTSC_OTM_NORMAL        2'h0
`define ELTSC_OTM_TRISTATE      2'h1
`define ELTSC_OTM_LOW           2'h2
`define ELTSC_OTM_HIGH          2'h3
`endif

// ---- rtl/eltsc_sig_mem.v ----
`timescale 1ns/1ps
`include "eltsc_defines.vh"
// Sixteen-byte transmit signaling store with registered read
module eltsc_sig_mem (
  input  wire       clk_in,
  input  wire       wr_en_in,
  input  wire [3:0] wr_addr_in,
  input  wire [7:0] wr_data_in,
  input  wire [3:0] rd_addr_in,
  output reg  [7:0] rd_data_out
);
  reg [7:0] mem [0:`ELTSC_SIG_COUNT-1];

  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule

// ---- rtl/eltsc_top.v ----
`timescale 1ns/1ps
`include "eltsc_defines.vh"
// Functional notes
// - Both sync bits clear: line sends and receives ordinary E1.
// - Only transmit sync set: transmitter sends sync signal, receiver E1.
// - Only line sync bit set: both directions use sync signal.
// - Both set: receiver takes sync signal, transmitter sends E1.
// - Sync signal is a 2.048MHz clock-type signal, not framed E1.
// - Output test code: 00 normal, 01 tri-state, 10 low, 11 high.
// - Signaling read select picks receive (0) or transmit (1) data.
// - Status meaning select: 0 loss of tx clock, 1 signaling change.
// - Timeslot-16 select 1 inserts signaling registers into transmit path.
// - Rising edge of software reset bit clears all control register bits; signaling registers keep their values.
// - Analog loopback routes selected tx data (ahead of output test forcing) to rx, ignoring external rx.
// - Ratio bit: 0 selects 1:2, 1 selects 1:1.36 or 1:1.6.
// - Line sync bit is bit 5 of control register at 16 hex.
module eltsc_top (
  input  wire       clk_sys_in,
  input  wire       nrst_in,
  // Host port
  input  wire       host_cs_in,
  input  wire       host_wr_in,
  input  wire       host_rd_in,
  input  wire [7:0] host_addr_in,
  input  wire [7:0] host_wdata_in,
  output reg  [7:0] host_rdata_out,
  output reg        host_rvalid_out,
  // Framer-side inputs (same clock)
  input  wire [7:0] rx_sig_data_in,
  input  wire       lost_tx_clk_in,
  input  wire       sig_changed_in,
  input  wire       tx_e1_pos_in,
  input  wire       tx_e1_neg_in,
  input  wire       tx_sync_clk_in,
  input  wire [4:0] tx_slot_in,
  // Line pins
  input  wire       rx_line_pos_in,
  input  wire       rx_line_neg_in,
  output reg        tx_line_pos_out,
  output reg        tx_line_neg_out,
  output reg        tx_line_oe_n_out,
  // Framer-side outputs
  output reg        rx_pos_out,
  output reg        rx_neg_out,
  output reg        rx_sync_mode_out,
  output reg        tx_sync_mode_out,
  output reg        status2_bit2_out,
  output reg        ts16_insert_out,
  output reg  [7:0] ts16_sig_out,
  output reg        transformer_ratio_sel_out,
  output reg        line_sync_iface_sel_out
);

  // ---------------------------------------------------------------
  // Reset synchroniser and pin synchronisers
  // ---------------------------------------------------------------
  reg        rst_meta_n;
  reg        rst_n;
  wire [1:0] rx_pin_raw;
  wire [1:0] rx_pin_sync;
  genvar     g;

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // Pins change off our clock; only the second stage feeds logic
  assign rx_pin_raw = {rx_line_neg_in, rx_line_pos_in};

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin_sync
      reg [1:0] stage;
      always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
          stage <= 2'h0;
        end else begin
          stage <= {stage[0], rx_pin_raw[g]};
        end
      end
      assign rx_pin_sync[g] = stage[1];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  reg  [7:0] line_iface_control;
  reg  [7:0] line_test_control;
  reg  [7:0] signaling_output_control;
  wire       wr_stb;
  wire       rd_stb;
  wire       sig_hit;
  wire       swrst_rise;
  wire       sig_wr;
  wire [7:0] sig_rd_data;
  wire [1:0] ctl_hit;

  function is_sig_addr;
    input [7:0] a;
    begin
      is_sig_addr = (a >= `ELTSC_ADDR_SIG_BASE) &&
                    (a <  `ELTSC_ADDR_SIG_BASE + 8'h10);
    end
  endfunction

  // Control register select: 0 none, 1 line iface, 2 line test, 3 signaling
  function [1:0] ctl_sel;
    input [7:0] a;
    begin
      if (a == `ELTSC_ADDR_LINE_IFACE) begin
        ctl_sel = 2'h1;
      end else if (a == `ELTSC_ADDR_LINE_TEST) begin
        ctl_sel = 2'h2;
      end else if (a == `ELTSC_ADDR_SIG_OUT) begin
        ctl_sel = 2'h3;
      end else begin
        ctl_sel = 2'h0;
      end
    end
  endfunction

  assign wr_stb  = host_cs_in & host_wr_in;
  assign rd_stb  = host_cs_in & host_rd_in & ~host_wr_in;
  assign sig_hit = is_sig_addr(host_addr_in);
  assign sig_wr  = wr_stb & sig_hit;
  assign ctl_hit = ctl_sel(host_addr_in);

  // Fires on a 1 written over a stored 0; firing clears the bit, so every write of 1 fires
  assign swrst_rise = wr_stb && (ctl_hit == 2'h3) &&
                      host_wdata_in[`ELTSC_BIT_SWRST] &&
                      !signaling_output_control[`ELTSC_BIT_SWRST];

  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      line_iface_control       <= `ELTSC_RST_BYTE;
      line_test_control        <= `ELTSC_RST_BYTE;
      signaling_output_control <= `ELTSC_RST_BYTE;
    end else if (swrst_rise) begin
      // Everything clears, the reset bit included, so a rewrite retriggers
      line_iface_control       <= `ELTSC_RST_BYTE;
      line_test_control        <= `ELTSC_RST_BYTE;
      signaling_output_control <= `ELTSC_RST_BYTE;
    end else if (wr_stb) begin
      if (ctl_hit == 2'h1) begin
        line_iface_control <= host_wdata_in;
      end else if (ctl_hit == 2'h2) begin
        line_test_control <= host_wdata_in & `ELTSC_MASK_LINE_TEST;
      end else if (ctl_hit == 2'h3) begin
        signaling_output_control <= host_wdata_in & `ELTSC_MASK_SIG_OUT;
      end
    end
  end

  // Transmit signaling store; a read address or timeslot index selects
  wire [3:0] sig_rd_addr;
  assign sig_rd_addr = rd_stb && sig_hit ? host_addr_in[3:0] : tx_slot_in[3:0];

  // Soft reset leaves this store alone; only control bits clear
  eltsc_sig_mem u_sig_mem (
    .clk_in      (clk_sys_in),
    .wr_en_in    (sig_wr),
    .wr_addr_in  (host_addr_in[3:0]),
    .wr_data_in  (host_wdata_in),
    .rd_addr_in  (sig_rd_addr),
    .rd_data_out (sig_rd_data)
  );

  // ---------------------------------------------------------------
  // Host read path: one cycle for control, two for signaling
  // ---------------------------------------------------------------
  reg       sig_rd_pend;
  reg       sig_rd_rx;
  reg [7:0] rx_sig_hold;

  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata_out  <= 8'h00;
      host_rvalid_out <= 1'b0;
      sig_rd_pend     <= 1'b0;
      sig_rd_rx       <= 1'b0;
      rx_sig_hold     <= 8'h00;
    end else begin
      host_rvalid_out <= 1'b0;
      sig_rd_pend     <= rd_stb & sig_hit;
      if (rd_stb && sig_hit) begin
        sig_rd_rx   <= ~signaling_output_control[`ELTSC_BIT_SIG_RD_SEL];
        rx_sig_hold <= rx_sig_data_in;
      end
      if (sig_rd_pend) begin
        host_rdata_out  <= sig_rd_rx ? rx_sig_hold : sig_rd_data;
        host_rvalid_out <= 1'b1;
      end else if (rd_stb && !sig_hit) begin
        host_rvalid_out <= 1'b1;
        if (ctl_hit == 2'h1) begin
          host_rdata_out <= line_iface_control;
        end else if (ctl_hit == 2'h2) begin
          host_rdata_out <= line_test_control;
        end else if (ctl_hit == 2'h3) begin
          host_rdata_out <= signaling_output_control;
        end else begin
          host_rdata_out <= 8'h00;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Line and framer controls
  // ---------------------------------------------------------------
  wire       line_sync_iface_sel;
  wire       tsync;
  wire       analog_loopback_en;
  wire [1:0] otm;
  reg        tx_pos_sel;
  reg        tx_neg_sel;
  reg        next_oe_n;
  reg        next_pos;
  reg        next_neg;

  assign line_sync_iface_sel = line_iface_control[`ELTSC_BIT_LINE_SYNC];
  assign tsync               = line_test_control[`ELTSC_BIT_TSYNC];
  assign analog_loopback_en  = line_test_control[`ELTSC_BIT_LOOPBACK];
  assign otm   = {signaling_output_control[`ELTSC_BIT_OTM_HI],
                  signaling_output_control[`ELTSC_BIT_OTM_LO]};

  // Transmit sync when modes 01 or 10; sync is a plain 2.048MHz clock
  wire tx_sync = line_sync_iface_sel ^ tsync;
  wire rx_sync = line_sync_iface_sel;

  always @* begin
    if (tx_sync) begin
      tx_pos_sel = tx_sync_clk_in;
      tx_neg_sel = ~tx_sync_clk_in;
    end else begin
      tx_pos_sel = tx_e1_pos_in;
      tx_neg_sel = tx_e1_neg_in;
    end
    next_oe_n = 1'b0;
    next_pos  = tx_pos_sel;
    next_neg  = tx_neg_sel;
    case (otm)
      `ELTSC_OTM_NORMAL: begin
        next_oe_n = 1'b0;
      end
      `ELTSC_OTM_TRISTATE: begin
        next_oe_n = 1'b1;
      end
      `ELTSC_OTM_LOW: begin
        next_pos = 1'b0;
        next_neg = 1'b0;
      end
      default: begin
        next_pos = 1'b1;
        next_neg = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_line_pos_out           <= 1'b0;
      tx_line_neg_out           <= 1'b0;
      tx_line_oe_n_out          <= 1'b1;
      rx_pos_out                <= 1'b0;
      rx_neg_out                <= 1'b0;
      rx_sync_mode_out          <= 1'b0;
      tx_sync_mode_out          <= 1'b0;
      status2_bit2_out          <= 1'b0;
      ts16_insert_out           <= 1'b0;
      ts16_sig_out              <= 8'h00;
      transformer_ratio_sel_out <= 1'b0;
      line_sync_iface_sel_out   <= 1'b0;
    end else begin
      tx_line_pos_out  <= next_pos;
      tx_line_neg_out  <= next_neg;
      tx_line_oe_n_out <= next_oe_n;
      // Loopback ignores the pins entirely
      rx_pos_out <= analog_loopback_en ? tx_pos_sel : rx_pin_sync[0];
      rx_neg_out <= analog_loopback_en ? tx_neg_sel : rx_pin_sync[1];
      rx_sync_mode_out <= rx_sync;
      tx_sync_mode_out <= tx_sync;
      status2_bit2_out <= signaling_output_control[`ELTSC_BIT_STSEL] ?
                          sig_changed_in : lost_tx_clk_in;
      ts16_insert_out  <= signaling_output_control[`ELTSC_BIT_TS16_INS];
      // Shared read port: value lags slot by two cycles, shows the host-addressed byte during host signaling reads
      ts16_sig_out <= signaling_output_control[`ELTSC_BIT_TS16_INS] ?
                      sig_rd_data : 8'h00;
      transformer_ratio_sel_out <= line_test_control[`ELTSC_BIT_RATIO];
      line_sync_iface_sel_out   <= line_sync_iface_sel;
    end
  end
endmodule

// ---- test/eltsc_monitor.sv ----
`timescale 1ns/1ps
module eltsc_monitor (
  input wire       clk_sys_in,
  input wire       nrst_in,
  input wire       host_cs_in,
  input wire       host_wr_in,
  input wire       host_rd_in,
  input wire [7:0] host_addr_in,
  input wire [7:0] host_rdata_out,
  input wire       host_rvalid_out,
  input wire       ts16_insert_out,
  input wire [7:0] ts16_sig_out,
  input wire       rx_sync_mode_out,
  input wire       line_sync_iface_sel_out
);
  // ----------
  // Host reads and framer outputs
  // ----------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  wire rd  = host_cs_in && host_rd_in && !host_wr_in;
  wire sig = host_addr_in[7:4] == 4'h3;
  wire unm = !sig && host_addr_in != 8'h16 && host_addr_in != 8'h1F && host_addr_in != 8'h2F;
  sequence s_sig_rd; rd && sig; endsequence
  sequence s_sig_ans; !host_rvalid_out ##1 host_rvalid_out; endsequence
  property p_sig_lat; s_sig_rd |=> s_sig_ans; endproperty
  property p_ctl_lat; rd && !sig |=> host_rvalid_out; endproperty
  property p_unm; rd && unm |=> host_rdata_out == 8'h00; endproperty
  property p_mask7; rd && host_addr_in == 8'h1F |=> (host_rdata_out & 8'hF2) == 8'h00; endproperty
  property p_mask6; rd && host_addr_in == 8'h2F |=> (host_rdata_out & 8'h07) == 8'h00; endproperty
  property p_hold; !host_rvalid_out |-> $stable(host_rdata_out); endproperty
  property p_ts16; !ts16_insert_out [*3] |-> ts16_sig_out == 8'h00; endproperty
  property p_rxs; $rose(rx_sync_mode_out) |-> ##[0:2] line_sync_iface_sel_out; endproperty
  a_sig_lat: assert property (p_sig_lat)
    else $error("signaling read answer timing wrong");
  a_ctl_lat: assert property (p_ctl_lat)
    else $error("control read answer missing");
  a_unm: assert property (p_unm)
    else $error("unmapped read not zero");
  a_mask7: assert property (p_mask7)
    else $error("unused line test bits read set");
  a_mask6: assert property (p_mask6)
    else $error("unused or reset bits of signaling control read set");
  a_hold: assert property (p_hold)
    else $error("read data moved without answer");
  a_ts16: assert property (p_ts16)
    else $error("signaling byte present with insertion off");
  a_rxs: assert property (p_rxs)
    else $error("receive sync mode without line sync bit");
endmodule
bind eltsc_top eltsc_monitor i_mon (.clk_sys_in, .nrst_in, .host_cs_in, .host_wr_in,
  .host_rd_in, .host_addr_in, .host_rdata_out, .host_rvalid_out, .ts16_insert_out,
  .ts16_sig_out, .rx_sync_mode_out, .line_sync_iface_sel_out);

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  reg        clk_sys_in = 1'b0, nrst_in = 1'b0, host_cs_in = 1'b0, host_wr_in = 1'b0;
  reg        host_rd_in = 1'b0, lost_tx_clk_in = 1'b0, sig_changed_in = 1'b0;
  reg        tx_e1_pos_in = 1'b0, tx_e1_neg_in = 1'b0, tx_sync_clk_in = 1'b0;
  reg        rx_line_pos_in = 1'b0, rx_line_neg_in = 1'b0;
  reg  [7:0] host_addr_in = 8'h00, host_wdata_in = 8'h00, rx_sig_data_in = 8'h00;
  reg  [4:0] tx_slot_in = 5'h00;
  wire [7:0] host_rdata_out, ts16_sig_out;
  wire       host_rvalid_out, tx_line_pos_out, tx_line_neg_out, tx_line_oe_n_out;
  wire       rx_pos_out, rx_neg_out, rx_sync_mode_out, tx_sync_mode_out;
  wire       status2_bit2_out, ts16_insert_out, transformer_ratio_sel_out;
  wire       line_sync_iface_sel_out;
  integer    n_fail = 0, samples_checked = 0, i;
  reg [23:0] rows [0:6];
  always #25 clk_sys_in = ~clk_sys_in;
  eltsc_top i_dut (.clk_sys_in, .nrst_in, .host_cs_in, .host_wr_in, .host_rd_in,
    .host_addr_in, .host_wdata_in, .host_rdata_out, .host_rvalid_out, .rx_sig_data_in,
    .lost_tx_clk_in, .sig_changed_in, .tx_e1_pos_in, .tx_e1_neg_in, .tx_sync_clk_in,
    .tx_slot_in, .rx_line_pos_in, .rx_line_neg_in, .tx_line_pos_out, .tx_line_neg_out,
    .tx_line_oe_n_out, .rx_pos_out, .rx_neg_out, .rx_sync_mode_out, .tx_sync_mode_out,
    .status2_bit2_out, .ts16_insert_out, .ts16_sig_out, .transformer_ratio_sel_out,
    .line_sync_iface_sel_out);
  // ---------------
  // Shared tasks
  // ---------------
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g); begin
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
    end
  end endtask
  // One request, then wait a bounded time for the answer on reads
  task bus(input w, input [7:0] a, input [7:0] d, input [7:0] e); integer k; begin
    @(posedge clk_sys_in);
    host_cs_in <= 1'b1;
    host_wr_in <= w;
    host_rd_in <= !w;
    host_addr_in <= a;
    host_wdata_in <= d;
    @(posedge clk_sys_in);
    host_cs_in <= 1'b0;
    host_wr_in <= 1'b0;
    host_rd_in <= 1'b0;
    #1;
    k = 0;
    while (!w && k < 4 && host_rvalid_out !== 1'b1) begin
      @(posedge clk_sys_in);
      #1;
      k = k + 1;
    end
    if (!w) chk("rvalid", 8'h01, {7'h00, host_rvalid_out});
    if (!w) chk("rdata", e, host_rdata_out);
  end endtask
  task settle; begin
    repeat (6) @(posedge clk_sys_in);
    #1;
  end endtask
  task close_out; begin
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end endtask
  initial begin
    #250000;
    n_fail = n_fail + 1;
    close_out;
  end
  // ---------------
  // Main sequence
  // ---------------
  initial begin
    rows[0] = 24'h1F0D0D;
    rows[1] = 24'h1F0000;
    rows[2] = 24'h2FF8F8;
    rows[3] = 24'h2F3838;
    rows[4] = 24'h16FFFF;
    rows[5] = 24'h160000;
    rows[6] = 24'h44AA00;
    repeat (5) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    bus(0, 8'h1F, 8'h00, 8'h00);
    bus(0, 8'h2F, 8'h00, 8'h00);
    for (i = 0; i < 7; i = i + 1) begin
      bus(1, rows[i][23:16], rows[i][15:8], 8'h00);
      bus(0, rows[i][23:16], 8'h00, rows[i][7:0]);
    end
    tx_sync_clk_in <= 1'b1;
    tx_e1_neg_in <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      bus(1, 8'h16, {2'h0, i[1], 5'h00}, 8'h00);
      bus(1, 8'h1F, {7'h00, i[0]}, 8'h00);
      settle;
      chk("rxsync", {7'h00, i[1]}, {7'h00, rx_sync_mode_out});
      chk("txsync", {7'h00, i[1] ^ i[0]}, {7'h00, tx_sync_mode_out});
      chk("txclk", {7'h00, i[1] ^ i[0]}, {7'h00, tx_line_pos_out});
      chk("txnegs", {7'h00, i[1] ~^ i[0]}, {7'h00, tx_line_neg_out});
    end
    bus(1, 8'h16, 8'h00, 8'h00);
    bus(1, 8'h1F, 8'h00, 8'h00);
    tx_e1_pos_in <= 1'b1;
    tx_e1_neg_in <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      bus(1, 8'h2F, {i[1:0], 6'h00}, 8'h00);
      settle;
      chk("oe_n", {7'h00, i == 1}, {7'h00, tx_line_oe_n_out});
      if (i != 1) chk("txpos", {7'h00, i != 2}, {7'h00, tx_line_pos_out});
      if (i != 1) chk("txneg", {7'h00, i == 3}, {7'h00, tx_line_neg_out});
    end
    for (i = 0; i < 4; i = i + 1) begin
      lost_tx_clk_in <= i[1];
      sig_changed_in <= ~i[1];
      bus(1, 8'h2F, {3'h0, i[0], 4'h0}, 8'h00);
      settle;
      chk("stat", {7'h00, i[0] ^ i[1]}, {7'h00, status2_bit2_out});
    end
    rx_sig_data_in <= 8'hC3;
    bus(1, 8'h35, 8'h5A, 8'h00);
    bus(1, 8'h2F, 8'h00, 8'h00);
    bus(0, 8'h35, 8'h00, 8'hC3);
    bus(1, 8'h2F, 8'h20, 8'h00);
    bus(0, 8'h35, 8'h00, 8'h5A);
    tx_slot_in <= 5'h05;
    bus(1, 8'h2F, 8'h08, 8'h00);
    settle;
    chk("ts16", 8'h5A, ts16_sig_out);
    chk("ins", 8'h01, {7'h00, ts16_insert_out});
    bus(1, 8'h2F, 8'h00, 8'h00);
    settle;
    chk("ts16off", 8'h00, ts16_sig_out);
    rx_line_neg_in <= 1'b1;
    bus(1, 8'h1F, 8'h0C, 8'h00);
    settle;
    chk("ratio", 8'h01, {7'h00, transformer_ratio_sel_out});
    chk("loop", 8'h01, {7'h00, rx_pos_out});
    chk("loopn", 8'h00, {7'h00, rx_neg_out});
    bus(1, 8'h1F, 8'h00, 8'h00);
    settle;
    chk("ratio0", 8'h00, {7'h00, transformer_ratio_sel_out});
    chk("noloop", 8'h00, {7'h00, rx_pos_out});
    chk("noloopn", 8'h01, {7'h00, rx_neg_out});
    // Rising reset bit clears all three control registers
    bus(1, 8'h2F, 8'hF8, 8'h00);
    bus(1, 8'h16, 8'h20, 8'h00);
    bus(1, 8'h1F, 8'h0D, 8'h00);
    bus(1, 8'h2F, 8'hF9, 8'h00);
    bus(0, 8'h1F, 8'h00, 8'h00);
    bus(0, 8'h2F, 8'h00, 8'h00);
    bus(0, 8'h16, 8'h00, 8'h00);
    bus(1, 8'h1F, 8'h04, 8'h00);
    bus(1, 8'h2F, 8'h01, 8'h00);
    bus(0, 8'h1F, 8'h00, 8'h00);
    close_out;
  end
endmodule
